// File: core/pce_pkg.sv
// Purpose: Shared constants and types for the pin change edge interrupt block
// Assumes: 8-bit register data over a plain strobe port
// Notes: Register offsets are word indices on the local port
`default_nettype none
package pce_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned PORTA_W = 6;
    localparam int unsigned PORTB_W = 4;
    localparam int unsigned PORTB_LSB = 4;
    localparam int unsigned PINS_W = PORTA_W + PORTB_W;

    // Register map
    localparam logic [3:0] OFS_A_RISE = 4'h0;
    localparam logic [3:0] OFS_A_FALL = 4'h1;
    localparam logic [3:0] OFS_A_FLAG = 4'h2;
    localparam logic [3:0] OFS_B_RISE = 4'h3;
    localparam logic [3:0] OFS_B_FALL = 4'h4;
    localparam logic [3:0] OFS_B_FLAG = 4'h5;
    localparam logic [3:0] OFS_CTRL = 4'h6;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h7;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

    // Control register fields
    localparam int unsigned CTRL_IRQ_EN_BIT = 0;
    localparam int unsigned CTRL_SUMMARY_BIT = 1;
    localparam int unsigned CTRL_SLEEP_BIT = 2;

    // Event status register fields
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_EDGE_BIT = 0;
    localparam int unsigned EVT_WAKE_BIT = 1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_A = 6'h00;
    localparam logic [3:0] RST_B = 4'h0;
    localparam logic [1:0] RST_EVT = 2'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pce_bus_s;

    typedef struct packed {
        logic [5:0] a;
        logic [3:0] b;
    } pce_pins_s;

    typedef enum logic {
        PWR_RUN,
        PWR_SLEEP
    } pce_pwr_e;
endpackage
`default_nettype wire

// File: core/pce_sync.sv
// Purpose: Two-stage synchroniser with a previous-sample stage for edge detection
// Assumes: Inputs asynchronous to CLK_SYS_I
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pce_sync #(
    parameter int unsigned WIDTH = 10
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [2:0] primed_q;

    // Primed gate stops reset values from posing as an edge
    // Three edges pass before prev_q holds a real pin sample
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            primed_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            primed_q <= {primed_q[1:0], 1'b1};
        end
    end

    assign rise_o = primed_q[2] ? (sync_q & ~prev_q) : '0;
    assign fall_o = primed_q[2] ? (~sync_q & prev_q) : '0;
    assign level_o = sync_q;
endmodule
`default_nettype wire

// File: core/pce_top.sv
// Purpose: Pin change edge interrupt logic for port A and optional port B pins
// Assumes: Pins asynchronous; registers on a plain strobe port, 8-bit data
// Notes: Port B present when HAS_PORTB is 1, otherwise reads as zero
//
// Functional notes
// RQ1 - With irq enable set, a recorded pin change wakes the device from sleep.
// RQ2 - Edges seen during sleep are in the flags before the wake request.
// RQ3 - Port A rise enables occupy bits 5-0; a one arms rising detection.
// RQ4 - Port A fall enables occupy bits 5-0; a one arms falling detection.
// RQ5 - Flag sets on an enabled rising or enabled falling edge of its pin.
// RQ6 - A pin with both enables zero never sets its flag.
// RQ7 - Only hardware sets flags; software writing zero clears them.
// RQ8 - Hardware set acts independently of software writes to the flags.
// RQ9 - Port A register bits 7-6 read zero and ignore writes.
// RQ10 - Port B rise enables in bits 7-4; bits 3-0 read zero.
// RQ11 - Port B fall enables in bits 7-4; low bits read zero.
// RQ12 - All enables and flags reset to zero on any reset.
// RQ13 - Summary flag is the OR of all port A and port B flags.
// RQ14 - Irq enable clear keeps detection running but raises no request; enabled edges still set event bit 0, which raises IRQ_O if unmasked.
// RQ15 - An edge during a clearing write leaves that flag set.
// RQ16 - Software clears flags by masked read-modify-write to avoid losing edges.
// RQ17 - Pins are synchronised; edges compare current and previous samples.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pce_top #(
    parameter bit HAS_PORTB = 1'b1
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    // Register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // Pins
    input wire logic [5:0] PORTA_PIN_I,
    input wire logic [3:0] PORTB_PIN_I,
    // Power state from the core
    input wire logic SLEEP_ENTER_I,
    // Interrupt and wake
    output logic PIN_CHANGE_IRQ_O,
    output logic WAKE_O,
    output logic IRQ_O
);
    pce_pkg::pce_bus_s bus;
    pce_pkg::pce_pins_s pins;
    pce_pkg::pce_pins_s rise;
    pce_pkg::pce_pins_s fall;
    pce_pkg::pce_pins_s hit;
    pce_pkg::pce_pwr_e pwr_q;
    pce_pkg::pce_pwr_e pwr_d;

    logic [5:0] a_rise_q;
    logic [5:0] a_fall_q;
    logic [5:0] a_flag_q;
    logic [5:0] a_flag_d;
    logic [3:0] b_rise_q;
    logic [3:0] b_fall_q;
    logic [3:0] b_flag_q;
    logic [3:0] b_flag_d;
    logic irq_en_q;
    logic [1:0] evt_q;
    logic [1:0] evt_d;
    logic [1:0] mask_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [9:0] rise_vec;
    logic [9:0] fall_vec;
    logic [3:0] b_gate;

    function automatic logic [7:0] pad_a(input logic [5:0] v);
        pad_a = {2'h0, v};
    endfunction

    function automatic logic [7:0] pad_b(input logic [3:0] v);
        pad_b = {v, 4'h0};
    endfunction

    function automatic logic wr_hit(input pce_pkg::pce_bus_s b, input logic [3:0] ofs);
        wr_hit = b.wr && (b.addr == ofs);
    endfunction

    assign bus = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};
    assign pins = '{a: PORTA_PIN_I, b: PORTB_PIN_I};

    // Missing port B pins are still synchronised; b_gate masks their edges so they never set flags
    pce_sync #(
        .WIDTH(pce_pkg::PINS_W)
    ) u_sync (
        .clk_i(CLK_SYS_I),
        .srst_i(SRST_I),
        .async_i(pins), // RQ17
        .rise_o(rise_vec),
        .fall_o(fall_vec),
        .level_o()
    );

    assign rise = rise_vec;
    assign fall = fall_vec;
    assign b_gate = HAS_PORTB ? 4'hf : 4'h0;

    // Per-pin hit: enabled rising or enabled falling edge
    assign hit.a = (rise.a & a_rise_q) | (fall.a & a_fall_q); // RQ3 RQ4 RQ5 RQ6
    assign hit.b = ((rise.b & b_rise_q) | (fall.b & b_fall_q)) & b_gate; // RQ10 RQ11 RQ5 RQ6

    // Software write lands first, hardware set is ORed on top so it always wins
    assign a_flag_d = (wr_hit(bus, pce_pkg::OFS_A_FLAG) ? bus.wdata[5:0] & a_flag_q : a_flag_q)
        | hit.a; // RQ7 RQ8 RQ15
    assign b_flag_d = ((wr_hit(bus, pce_pkg::OFS_B_FLAG) ? bus.wdata[7:4] & b_flag_q : b_flag_q)
        | hit.b) & b_gate; // RQ7 RQ8 RQ15

    // Summary flag and gated request
    assign PIN_CHANGE_IRQ_O = irq_en_q && ((|a_flag_q) || (|b_flag_q)); // RQ14

    // Sleep tracking: flags are already registered when wake rises
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            pce_pkg::PWR_RUN: begin
                if (SLEEP_ENTER_I) begin
                    pwr_d = pce_pkg::PWR_SLEEP;
                end
            end
            pce_pkg::PWR_SLEEP: begin
                if (PIN_CHANGE_IRQ_O) begin
                    pwr_d = pce_pkg::PWR_RUN; // RQ1
                end
            end
        endcase
    end

    // Wake is driven from registered flags, so flags lead the first instruction
    assign WAKE_O = (pwr_q == pce_pkg::PWR_SLEEP) && PIN_CHANGE_IRQ_O; // RQ1 RQ2

    // Event status: set wins over write-one-to-clear
    assign evt_d = (wr_hit(bus, pce_pkg::OFS_IRQ_STAT) ? evt_q & ~bus.wdata[1:0] : evt_q)
        | {WAKE_O, (|hit.a) || (|hit.b)};
    assign IRQ_O = |(evt_q & mask_q);

    always_comb begin
        rdata_d = pce_pkg::RST_BYTE;
        unique case (bus.addr)
            pce_pkg::OFS_A_RISE: rdata_d = pad_a(a_rise_q); // RQ9
            pce_pkg::OFS_A_FALL: rdata_d = pad_a(a_fall_q); // RQ9
            pce_pkg::OFS_A_FLAG: rdata_d = pad_a(a_flag_q); // RQ9
            pce_pkg::OFS_B_RISE: rdata_d = pad_b(b_rise_q); // RQ10
            pce_pkg::OFS_B_FALL: rdata_d = pad_b(b_fall_q); // RQ11
            pce_pkg::OFS_B_FLAG: rdata_d = pad_b(b_flag_q);
            pce_pkg::OFS_CTRL: begin
                rdata_d[pce_pkg::CTRL_IRQ_EN_BIT] = irq_en_q;
                rdata_d[pce_pkg::CTRL_SUMMARY_BIT] = (|a_flag_q) || (|b_flag_q); // RQ13
                rdata_d[pce_pkg::CTRL_SLEEP_BIT] = (pwr_q == pce_pkg::PWR_SLEEP);
            end
            pce_pkg::OFS_IRQ_STAT: rdata_d = {6'h00, evt_q};
            pce_pkg::OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
            default: rdata_d = pce_pkg::RST_BYTE;
        endcase
    end

    // Enables, writable part only
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            a_rise_q <= pce_pkg::RST_A; // RQ12
            a_fall_q <= pce_pkg::RST_A; // RQ12
            b_rise_q <= pce_pkg::RST_B; // RQ12
            b_fall_q <= pce_pkg::RST_B; // RQ12
            irq_en_q <= 1'b0;
            mask_q <= pce_pkg::RST_EVT;
        end else begin
            if (wr_hit(bus, pce_pkg::OFS_A_RISE)) a_rise_q <= bus.wdata[5:0]; // RQ3 RQ9
            if (wr_hit(bus, pce_pkg::OFS_A_FALL)) a_fall_q <= bus.wdata[5:0]; // RQ4 RQ9
            if (wr_hit(bus, pce_pkg::OFS_B_RISE)) b_rise_q <= bus.wdata[7:4] & b_gate; // RQ10
            if (wr_hit(bus, pce_pkg::OFS_B_FALL)) b_fall_q <= bus.wdata[7:4] & b_gate; // RQ11
            if (wr_hit(bus, pce_pkg::OFS_CTRL)) irq_en_q <= bus.wdata[pce_pkg::CTRL_IRQ_EN_BIT];
            if (wr_hit(bus, pce_pkg::OFS_IRQ_MASK)) mask_q <= bus.wdata[1:0];
        end
    end

    // Flags, status, power state and read data
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            a_flag_q <= pce_pkg::RST_A; // RQ12
            b_flag_q <= pce_pkg::RST_B; // RQ12
            evt_q <= pce_pkg::RST_EVT;
            pwr_q <= pce_pkg::PWR_RUN;
            rdata_q <= pce_pkg::RST_BYTE;
        end else begin
            a_flag_q <= a_flag_d;
            b_flag_q <= b_flag_d;
            evt_q <= evt_d;
            pwr_q <= pwr_d;
            rdata_q <= bus.rd ? rdata_d : pce_pkg::RST_BYTE;
        end
    end

    assign REG_RDATA_O = rdata_q;
endmodule
`default_nettype wire

// File: verification/pce_top_properties.sv
// Purpose: Port-level checks for pce_top
// Assumes: One clock, synchronous reset
// Notes: Register contents are seen only through read answers
`timescale 1ns/1ps
`default_nettype none
module pce_top_properties (
    // Clock, reset and register port
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    // Pins and outputs
    input wire logic [5:0] PORTA_PIN_I,
    input wire logic [3:0] PORTB_PIN_I,
    input wire logic SLEEP_ENTER_I,
    input wire logic PIN_CHANGE_IRQ_O,
    input wire logic WAKE_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);
    wire rd_a = REG_RD_I && (REG_ADDR_I <= 4'h2);
    wire rd_b = REG_RD_I && (REG_ADDR_I >= 4'h3) && (REG_ADDR_I <= 4'h5);
    wire rd_c = REG_RD_I && (REG_ADDR_I == pce_pkg::OFS_CTRL);
    wire [9:0] pins = {PORTA_PIN_I, PORTB_PIN_I};
    property p_a_hi; rd_a |=> REG_RDATA_O[7:6] == 2'h0; endproperty
    a_a_hi: assert property (p_a_hi) else $error("port A upper bits not zero");
    property p_b_lo; rd_b |=> REG_RDATA_O[3:0] == 4'h0; endproperty
    a_b_lo: assert property (p_b_lo) else $error("port B lower bits not zero");
    property p_req_on; rd_c && PIN_CHANGE_IRQ_O |=> REG_RDATA_O[1:0] == 2'h3; endproperty
    a_req_on: assert property (p_req_on) else $error("request without enable or summary");
    property p_req_off; rd_c && !PIN_CHANGE_IRQ_O |=> REG_RDATA_O[1:0] != 2'h3; endproperty
    a_req_off: assert property (p_req_off) else $error("request missing");
    property p_src; $rose(PIN_CHANGE_IRQ_O) |-> $past(REG_WR_I) || ($past(pins, 3) != $past(pins, 4)); endproperty
    a_src: assert property (p_src) else $error("request without pin edge");
    property p_wake; WAKE_O |-> PIN_CHANGE_IRQ_O ##1 !WAKE_O; endproperty
    a_wake: assert property (p_wake) else $error("bad wake pulse");
    property p_entry; SLEEP_ENTER_I && PIN_CHANGE_IRQ_O |=> WAKE_O; endproperty
    a_entry: assert property (p_entry) else $error("no wake on sleep entry");
    property p_rst; $fell(SRST_I) |-> !IRQ_O && !PIN_CHANGE_IRQ_O && !WAKE_O && REG_RDATA_O == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule
`default_nettype wire

// File: verification/pce_pin_model.sv
// Purpose: Far-side model of the external pin drivers
// Assumes: Commands change just after a rising edge
// Notes: No bounce; short glitches are not modelled
`timescale 1ns/1ps
`default_nettype none
module pce_pin_model (
    // Command
    input wire pce_pkg::pce_pins_s want_i,
    // Pins
    output wire logic [5:0] porta_o,
    output wire logic [3:0] portb_o
);
    assign porta_o = want_i.a;
    assign portb_o = want_i.b;
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench for pce_top
// Assumes: Read data stand the cycle after the read strobe
// Notes: A pin edge reaches the flags in three edges; waits of five leave margin
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic rd_q = 1'b0;
    pce_pkg::pce_pins_s want = '0;
    logic [15:0] rnd = 16'hcff8;
    logic [7:0] exp_q[$];
    logic [5:0] fa = 6'h00;
    logic [3:0] fb = 4'h0;
    int fail_count = 0;
    int cmp_count = 0;
    wire [7:0] rdata;
    wire [5:0] pa;
    wire [3:0] pb;
    wire pc_irq;
    wire wake;
    wire irq;
    always #10 clk = ~clk;
    pce_pin_model pins (.want_i(want), .porta_o(pa), .portb_o(pb));
    pce_top dut (.CLK_SYS_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .PORTA_PIN_I(pa), .PORTB_PIN_I(pb), .SLEEP_ENTER_I(sleep),
        .PIN_CHANGE_IRQ_O(pc_irq), .WAKE_O(wake), .IRQ_O(irq));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // A gap cycle after each strobe keeps one assignment per signal per step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic out_chk(input string what, input logic [7:0] e);
        @(negedge clk);
        chk(what, {5'h00, irq, wake, pc_irq}, e);
        @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q && exp_q.size() != 0) begin
            chk("rdata", rdata, exp_q.pop_front());
        end
    end
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rd_reg((i == 9) ? 4'hf : 4'(i), 8'h00);
        end
        wr_reg(4'h0, 8'hff);
        wr_reg(4'h1, 8'hff);
        wr_reg(4'h3, 8'hff);
        wr_reg(4'h4, 8'hff);
        rd_reg(4'h0, 8'h3f);
        rd_reg(4'h1, 8'h3f);
        rd_reg(4'h3, 8'hf0);
        rd_reg(4'h4, 8'hf0);
        wr_reg(4'h6, 8'h01);
        wr_reg(4'h8, 8'h03);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            fa = fa | (want.a ^ rnd[9:4]);
            fb = fb | (want.b ^ rnd[3:0]);
            want <= rnd[9:0];
            repeat (5) @(posedge clk);
        end
        rd_reg(4'h2, {2'h0, fa});
        rd_reg(4'h5, {fb, 4'h0});
        rd_reg(4'h7, 8'h01);
        out_chk("outputs", 8'h05);
        wr_reg(4'h7, 8'h03);
        wr_reg(4'h2, {2'h3, ~fa});
        wr_reg(4'h5, 8'h00);
        out_chk("outputs", 8'h00);
        wr_reg(4'h2, 8'hff);
        rd_reg(4'h2, 8'h00);
        $display("test edges done");
        for (int i = 0; i < 5; i++) begin
            wr_reg(4'(i), 8'h00);
        end
        want <= ~want;
        repeat (5) @(posedge clk);
        rd_reg(4'h2, 8'h00);
        rd_reg(4'h5, 8'h00);
        want.a[0] <= 1'b0;
        repeat (5) @(posedge clk);
        wr_reg(4'h0, 8'h01);
        want.a[0] <= 1'b1;
        repeat (2) @(posedge clk);
        wr_reg(4'h2, 8'h00);
        rd_reg(4'h2, 8'h01);
        wr_reg(4'h6, 8'h00);
        rd_reg(4'h6, 8'h02);
        out_chk("outputs", 8'h04);
        $display("test clearing done");
        want.a[0] <= 1'b0;
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h7, 8'h03);
        wr_reg(4'h6, 8'h01);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        want.a[0] <= 1'b1;
        for (int i = 0; i < 10 && wake !== 1'b1; i++) @(negedge clk);
        chk("wake", {6'h00, wake, pc_irq}, 8'h03);
        @(posedge clk);
        rd_reg(4'h2, 8'h01);
        rd_reg(4'h7, 8'h03);
        rd_reg(4'h6, 8'h03);
        wr_reg(4'h8, 8'h00);
        out_chk("outputs", 8'h01);
        wr_reg(4'h8, 8'h02);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        out_chk("outputs", 8'h07);
        wr_reg(4'h7, 8'h03);
        out_chk("outputs", 8'h01);
        $display("test sleep done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_reg(4'h2, 8'h00);
        rd_reg(4'h6, 8'h00);
        $display("test reset again done");
        tally_and_finish();
    end
endmodule
bind pce_top pce_top_properties u_props (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .PORTA_PIN_I(PORTA_PIN_I), .PORTB_PIN_I(PORTB_PIN_I), .SLEEP_ENTER_I(SLEEP_ENTER_I),
    .PIN_CHANGE_IRQ_O(PIN_CHANGE_IRQ_O), .WAKE_O(WAKE_O), .IRQ_O(IRQ_O));
`default_nettype wire
